// File: hdl/ucp_cfg.svh
// offsets, field positions, reset values and timing counts for the unary/compare/irq op unit
// assumes an 8-bit register space and a 16-bit program counter
`ifndef UCP_CFG_SVH
`define UCP_CFG_SVH

// register addresses inside the 8-bit register space
`define UCP_FLAGS_ADDR 8'hD5
`define UCP_SYSMODE_ADDR 8'hDE
// base of the sixteen working registers
`define UCP_WREG_BASE 8'hC0

// condition flag bit positions
`define UCP_FLAG_C 7
`define UCP_FLAG_Z 6
`define UCP_FLAG_S 5
`define UCP_FLAG_V 4
// global interrupt enable bit in the system mode register
`define UCP_GIE_BIT 3

// reset values
`define UCP_FLAGS_RST 8'h00
`define UCP_SYSMODE_RST 8'h00
`define UCP_PC_RST 16'h0000

// opcodes
`define UCP_OP_CARRY_INV 8'hEF
`define UCP_OP_IRQ_DIS 8'h8F
`define UCP_OP_IRQ_EN 8'h9F
`define UCP_OP_IDLE 8'h6F
`define UCP_OP_DEC_R 8'h00
`define UCP_OP_DEC_IR 8'h01
`define UCP_OP_INC_R 8'h20
`define UCP_OP_INC_IR 8'h21
`define UCP_OP_COM_R 8'h60
`define UCP_OP_COM_IR 8'h61
`define UCP_OP_CLR_R 8'hB0
`define UCP_OP_CLR_IR 8'hB1
`define UCP_OP_CP_RR 8'hA2
`define UCP_OP_CP_RIR 8'hA3
`define UCP_OP_CP_FF 8'hA4
`define UCP_OP_CP_FIR 8'hA5
`define UCP_OP_CP_FIM 8'hA6
// low nibble of the one-byte working register increment
`define UCP_INC_W_NIB 4'hE

// sign boundaries for overflow detection
`define UCP_MAX_POS 8'h7F
`define UCP_MIN_NEG 8'h80

// cycle counts of each instruction
`define UCP_CYC_SHORT 3'h4
`define UCP_CYC_LONG 3'h6

`endif

// File: hdl/ucp_pkg.sv
// types shared by the unary/compare/irq op unit
// assumes ucp_cfg.svh for all numeric constants
package ucp_pkg;

  // sequencer steps of one instruction
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_OPND1,
    ST_PTR,
    ST_SRC,
    ST_OPND2,
    ST_EXEC,
    ST_PAD,
    ST_IDLE
  } ucp_state_t;

  // software register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ucp_bus_req_t;

  // register file write/read port driven by the unit
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
  } ucp_rf_port_t;

  // complete state of the unit
  typedef struct packed {
    ucp_state_t st;
    logic [15:0] pc;
    logic [15:0] ret_pc;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] aux;
    logic [7:0] dval;
    logic [7:0] sval;
    logic [7:0] daddr;
    logic [2:0] cnt;
    logic [2:0] len;
    logic [7:0] flags;
    logic [7:0] sysmode;
    logic [7:0] rdata;
  } ucp_core_t;

endpackage

// File: hdl/ucp_core.sv
// execution unit for carry invert, clear, complement, compare, decrement, increment,
// global irq disable/enable and idle; assumes a register file with combinational read
// and a program memory with combinational read at pm_addr_o, all on clk_i
//
// Behaviour
// - EF toggles carry only, four cycles
// - clear writes zero, no flag change
// - complement inverts destination, 60 and 61
// - complement sets Z,S; clears V; keeps C
// - compare updates flags, writes no operand
// - compare carry is borrow; Z,S from difference
// - compare overflow from operand and result signs
// - compare four cycles register form, else six
// - decrement subtracts one, 00 and 01
// - decrement overflow only 80 to 7F
// - inc/dec set Z,S; keep carry
// - 8F clears global enable bit three
// - disabled requests stay pending, no vectoring
// - 9F sets global enable bit three
// - pending request serviced after re-enable
// - 6F gates cpu clock, oscillator runs
// - idle left on request or reset
// - increment adds one, rE 20 21
// - increment overflow only 7F to 80
// - flag register readable at D5
`timescale 1ns/1ps
`default_nettype none
`include "ucp_cfg.svh"

module ucp_core #(
  parameter logic [7:0] WREG_BASE = `UCP_WREG_BASE
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire ucp_pkg::ucp_bus_req_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  output logic [15:0] pm_addr_o,
  input wire logic [7:0] pm_data_i,
  output ucp_pkg::ucp_rf_port_t rf_o,
  input wire logic [7:0] rf_rdata_i,
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  output logic irq_ack_o,
  output logic [15:0] ret_pc_o,
  output logic cpu_clk_en_o,
  output logic [7:0] sysmode_o
);

  // working registers must sit on a sixteen-byte boundary
  if (WREG_BASE[3:0] != 4'h0)
  begin : g_chk
    $error("WREG_BASE must be sixteen-byte aligned");
  end

  ucp_pkg::ucp_core_t q, d;
  logic irq_take;
  ucp_pkg::ucp_rf_port_t rf_v;

  // internal flag and mode registers shadow their addresses on reads
  function automatic logic [7:0] map_f(input logic [7:0] a, input logic [7:0] fl,
                                       input logic [7:0] sm, input logic [7:0] ext);
    if (a == `UCP_FLAGS_ADDR)
    begin
      return fl;
    end
    else if (a == `UCP_SYSMODE_ADDR)
    begin
      return sm;
    end
    return ext;
  endfunction

  function automatic logic [7:0] wreg_f(input logic [3:0] n);
    return WREG_BASE | {4'h0, n};
  endfunction

  // vector only at an instruction boundary with global enable set
  assign irq_take = (q.st == ucp_pkg::ST_FETCH) && q.sysmode[`UCP_GIE_BIT] && irq_req_i;

  // next-state logic
  always_comb
  begin
    logic [7:0] res;
    logic [8:0] diff;
    logic wr;
    logic last;
    res = 8'h00;
    diff = 9'h000;
    wr = 1'b0;
    d = q;
    rf_v = '{addr: 8'h00, wdata: 8'h00, we: 1'b0};
    last = (q.cnt == (q.len - 3'h1));
    d.rdata = 8'h00;
    // software port: flag register at its own address, read data one cycle later
    if (bus_req_i.re)
    begin
      d.rdata = map_f(bus_req_i.addr, q.flags, q.sysmode, 8'h00);
    end
    if (bus_req_i.we)
    begin
      if (bus_req_i.addr == `UCP_FLAGS_ADDR)
      begin
        d.flags = bus_req_i.wdata;
      end
      else if (bus_req_i.addr == `UCP_SYSMODE_ADDR)
      begin
        d.sysmode = bus_req_i.wdata;
      end
    end
    if (q.st != ucp_pkg::ST_FETCH && q.st != ucp_pkg::ST_IDLE)
    begin
      d.cnt = q.cnt + 3'h1;
    end
    case (q.st)
      ucp_pkg::ST_FETCH:
      begin
        if (irq_take)
        begin
          // return address is the byte after the last instruction, idle included
          d.ret_pc = q.pc;
          d.pc = irq_vector_i;
          d.sysmode[`UCP_GIE_BIT] = 1'b0;
        end
        else
        begin
          d.op = pm_data_i;
          d.pc = q.pc + 16'h0001;
          d.cnt = 3'h1;
          d.len = `UCP_CYC_SHORT;
          d.st = ucp_pkg::ST_PAD;
          case (pm_data_i)
            `UCP_OP_CARRY_INV: d.flags[`UCP_FLAG_C] = ~q.flags[`UCP_FLAG_C];
            `UCP_OP_IRQ_DIS: d.sysmode[`UCP_GIE_BIT] = 1'b0;
            `UCP_OP_IRQ_EN: d.sysmode[`UCP_GIE_BIT] = 1'b1;
            `UCP_OP_DEC_R, `UCP_OP_DEC_IR, `UCP_OP_INC_R, `UCP_OP_INC_IR,
            `UCP_OP_COM_R, `UCP_OP_COM_IR, `UCP_OP_CLR_R, `UCP_OP_CLR_IR,
            `UCP_OP_CP_RR:
              d.st = ucp_pkg::ST_OPND1;
            `UCP_OP_CP_RIR, `UCP_OP_CP_FF, `UCP_OP_CP_FIR, `UCP_OP_CP_FIM:
            begin
              d.st = ucp_pkg::ST_OPND1;
              d.len = `UCP_CYC_LONG;
            end
            default:
            begin
              // one-byte increment of a working register
              if (pm_data_i[3:0] == `UCP_INC_W_NIB)
              begin
                rf_v.addr = wreg_f(pm_data_i[7:4]);
                d.daddr = rf_v.addr;
                d.dval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
                d.st = ucp_pkg::ST_EXEC;
              end
            end
          endcase
        end
      end
      ucp_pkg::ST_OPND1:
      begin
        d.b1 = pm_data_i;
        d.pc = q.pc + 16'h0001;
        d.st = ucp_pkg::ST_EXEC;
        case (q.op)
          `UCP_OP_CP_RR, `UCP_OP_CP_RIR:
          begin
            rf_v.addr = wreg_f(pm_data_i[7:4]);
            d.daddr = rf_v.addr;
            d.dval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
            d.st = ucp_pkg::ST_PTR;
          end
          `UCP_OP_CP_FF:
          begin
            rf_v.addr = pm_data_i;
            d.sval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
            d.st = ucp_pkg::ST_OPND2;
          end
          `UCP_OP_CP_FIR:
          begin
            rf_v.addr = pm_data_i;
            d.aux = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
            d.st = ucp_pkg::ST_SRC;
          end
          `UCP_OP_CP_FIM:
          begin
            rf_v.addr = pm_data_i;
            d.daddr = pm_data_i;
            d.dval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
            d.st = ucp_pkg::ST_OPND2;
          end
          default:
          begin
            // unary ops: odd opcode is register-indirect
            rf_v.addr = pm_data_i;
            if (q.op[0])
            begin
              d.aux = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
              d.st = ucp_pkg::ST_PTR;
            end
            else
            begin
              d.daddr = pm_data_i;
              d.dval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
            end
          end
        endcase
      end
      ucp_pkg::ST_PTR:
      begin
        d.st = ucp_pkg::ST_EXEC;
        case (q.op)
          `UCP_OP_CP_RR:
          begin
            rf_v.addr = wreg_f(q.b1[3:0]);
            d.sval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
          end
          `UCP_OP_CP_RIR:
          begin
            rf_v.addr = wreg_f(q.b1[3:0]);
            d.aux = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
            d.st = ucp_pkg::ST_SRC;
          end
          default:
          begin
            rf_v.addr = q.aux;
            d.daddr = q.aux;
            d.dval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
          end
        endcase
      end
      ucp_pkg::ST_SRC:
      begin
        rf_v.addr = q.aux;
        d.sval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
        d.st = (q.op == `UCP_OP_CP_FIR) ? ucp_pkg::ST_OPND2 : ucp_pkg::ST_EXEC;
      end
      ucp_pkg::ST_OPND2:
      begin
        d.pc = q.pc + 16'h0001;
        d.st = ucp_pkg::ST_EXEC;
        if (q.op == `UCP_OP_CP_FIM)
        begin
          d.sval = pm_data_i;
        end
        else
        begin
          rf_v.addr = pm_data_i;
          d.daddr = pm_data_i;
          d.dval = map_f(rf_v.addr, q.flags, q.sysmode, rf_rdata_i);
        end
      end
      ucp_pkg::ST_EXEC:
      begin
        case (q.op)
          `UCP_OP_DEC_R, `UCP_OP_DEC_IR:
          begin
            res = q.dval - 8'h01;
            wr = 1'b1;
            d.flags[`UCP_FLAG_V] = (q.dval == `UCP_MIN_NEG);
          end
          `UCP_OP_COM_R, `UCP_OP_COM_IR:
          begin
            res = ~q.dval;
            wr = 1'b1;
            d.flags[`UCP_FLAG_V] = 1'b0;
          end
          `UCP_OP_CLR_R, `UCP_OP_CLR_IR:
          begin
            res = 8'h00;
            wr = 1'b1;
          end
          `UCP_OP_CP_RR, `UCP_OP_CP_RIR, `UCP_OP_CP_FF, `UCP_OP_CP_FIR, `UCP_OP_CP_FIM:
          begin
            // flags only, operands untouched
            diff = {1'b0, q.dval} - {1'b0, q.sval};
            res = diff[7:0];
            d.flags[`UCP_FLAG_C] = diff[8];
            d.flags[`UCP_FLAG_V] = (q.dval[7] != q.sval[7]) && (diff[7] == q.sval[7]);
          end
          default:
          begin
            res = q.dval + 8'h01;
            wr = 1'b1;
            d.flags[`UCP_FLAG_V] = (q.dval == `UCP_MAX_POS);
          end
        endcase
        if (wr)
        begin
          rf_v.addr = q.daddr;
          rf_v.wdata = res;
          if (q.daddr == `UCP_FLAGS_ADDR)
          begin
            d.flags = res;
          end
          else if (q.daddr == `UCP_SYSMODE_ADDR)
          begin
            d.sysmode = res;
          end
          else
          begin
            rf_v.we = 1'b1;
          end
        end
        // zero and sign follow the result; clear leaves all flags alone
        if (q.op != `UCP_OP_CLR_R && q.op != `UCP_OP_CLR_IR)
        begin
          d.flags[`UCP_FLAG_Z] = (res == 8'h00);
          d.flags[`UCP_FLAG_S] = res[7];
        end
        d.st = last ? ucp_pkg::ST_FETCH : ucp_pkg::ST_PAD;
      end
      ucp_pkg::ST_PAD:
      begin
        // hold until the instruction has used its full cycle count
        if (last)
        begin
          d.st = (q.op == `UCP_OP_IDLE) ? ucp_pkg::ST_IDLE : ucp_pkg::ST_FETCH;
        end
      end
      ucp_pkg::ST_IDLE: d.st = irq_req_i ? ucp_pkg::ST_FETCH : ucp_pkg::ST_IDLE;
      default:
      begin
        d.st = ucp_pkg::ST_FETCH;
      end
    endcase
  end

  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q <= '{st: ucp_pkg::ST_FETCH, pc: `UCP_PC_RST, ret_pc: `UCP_PC_RST,
             flags: `UCP_FLAGS_RST, sysmode: `UCP_SYSMODE_RST, default: '0};
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  // outputs
  assign pm_addr_o = q.pc;
  assign rf_o = '{addr: rf_v.addr, wdata: rf_v.wdata, we: rf_v.we && ce_i};
  assign irq_ack_o = irq_take && ce_i;
  assign ret_pc_o = q.ret_pc;
  assign cpu_clk_en_o = (q.st != ucp_pkg::ST_IDLE);
  assign sysmode_o = q.sysmode;
  assign bus_rdata_o = q.rdata;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  wire fetch_go = ce_i && (q.st == ucp_pkg::ST_FETCH) && !irq_take;
  wire is_cp = (q.op[7:4] == 4'hA) && (q.op[3:0] >= 4'h2) && (q.op[3:0] <= 4'h6);

  a_carry_invert: assert property (fetch_go && pm_data_i == `UCP_OP_CARRY_INV && !bus_req_i.we
    |=> q.flags == ($past(q.flags) ^ 8'h80))
    else $error("carry invert changed wrong flags");
  a_irq_disable: assert property (fetch_go && pm_data_i == `UCP_OP_IRQ_DIS && !bus_req_i.we
    |=> !q.sysmode[`UCP_GIE_BIT] && q.flags == $past(q.flags))
    else $error("disable did not clear enable bit");
  a_irq_enable: assert property (fetch_go && pm_data_i == `UCP_OP_IRQ_EN && !bus_req_i.we
    |=> q.sysmode[`UCP_GIE_BIT])
    else $error("enable did not set enable bit");
  a_no_vector_off: assert property (ce_i && q.st == ucp_pkg::ST_FETCH && !q.sysmode[`UCP_GIE_BIT]
    |-> !irq_ack_o ##1 q.pc == $past(q.pc) + 16'h0001)
    else $error("vectored while globally disabled");
  a_idle_wake: assert property (q.st == ucp_pkg::ST_IDLE && irq_req_i && ce_i
    |=> cpu_clk_en_o && q.st == ucp_pkg::ST_FETCH)
    else $error("idle not left on request");
  a_idle_hold: assert property (q.st == ucp_pkg::ST_IDLE && !irq_req_i |=> !cpu_clk_en_o)
    else $error("idle left without request");
  a_cp_no_write: assert property (q.st == ucp_pkg::ST_EXEC && is_cp |-> !rf_o.we)
    else $error("compare wrote an operand");
  a_cycle_bound: assert property (fetch_go && pm_data_i == `UCP_OP_CP_FIM
    |=> (q.st != ucp_pkg::ST_FETCH) [*5] ##1 q.st == ucp_pkg::ST_FETCH || !ce_i)
    else $error("compare immediate did not take six cycles");
  a_dec_overflow: assert property (ce_i && q.st == ucp_pkg::ST_EXEC && q.op == `UCP_OP_DEC_R
    && q.daddr != `UCP_FLAGS_ADDR |=> q.flags[`UCP_FLAG_V] == ($past(q.dval) == `UCP_MIN_NEG))
    else $error("decrement overflow wrong");
  a_inc_overflow: assert property (ce_i && q.st == ucp_pkg::ST_EXEC && q.op == `UCP_OP_INC_R
    && q.daddr != `UCP_FLAGS_ADDR |=> q.flags[`UCP_FLAG_V] == ($past(q.dval) == `UCP_MAX_POS))
    else $error("increment overflow wrong");
  a_flag_read: assert property (ce_i && bus_req_i.re && bus_req_i.addr == `UCP_FLAGS_ADDR
    |=> bus_rdata_o == $past(q.flags))
    else $error("flag register read mismatch");

  c_compare: cover property (q.st == ucp_pkg::ST_EXEC && is_cp);
  c_idle_wake: cover property (q.st == ucp_pkg::ST_IDLE ##1 q.st == ucp_pkg::ST_FETCH);
  c_irq_taken: cover property (irq_ack_o);

endmodule

`default_nettype wire

// File: verif/ucp_mem_model.sv
// behavioural program memory and register file on the far side of the op unit
// assumes combinational reads and register file writes on the rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none

module ucp_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] pm_addr_i,
  output logic [7:0] pm_data_o,
  input wire ucp_pkg::ucp_rf_port_t rf_i,
  output logic [7:0] rf_rdata_o
);
  logic [7:0] pm [0:255];
  logic [7:0] rf [0:255];

  // combinational reads; upper program address bits are not decoded
  assign pm_data_o = pm[pm_addr_i[7:0]];
  assign rf_rdata_o = rf[rf_i.addr];

  // register file write port
  always @(posedge clk_i)
  begin
    if (rf_i.we === 1'b1)
    begin
      rf[rf_i.addr] <= rf_i.wdata;
    end
  end
endmodule

`default_nettype wire

// File: verif/tb_cpu_unary_compare_irq_ops.sv
// self-checking bench: runs a short program through the op unit and checks flags and registers
// assumes ucp_core and ucp_mem_model, a 100 ns clock and a fixed cycle count per instruction
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_unary_compare_irq_ops;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  ucp_pkg::ucp_bus_req_t bus_req = '0;
  logic irq_req = 1'b0;
  logic [15:0] irq_vector = 16'h0060;
  logic [7:0] bus_rdata, pm_data, rf_rdata, sysmode;
  logic [15:0] pm_addr, ret_pc, saved;
  ucp_pkg::ucp_rf_port_t rf_port;
  logic irq_ack, cpu_clk_en;
  int bad_count = 0;
  int n_tests = 0;
  int ack_n = 0;
  int i;
  logic pend = 1'b0;
  logic [7:0] pend_fl;
  // program bytes from address 00
  logic [7:0] prog [0:33] = '{8'hEF, 8'hA2, 8'h12, 8'h00, 8'h10, 8'h20, 8'h12, 8'h61, 8'h11, 8'hB1, 8'h11,
    8'h1E, 8'hA6, 8'h30, 8'h05, 8'hA4, 8'h31, 8'h30, 8'hA3, 8'h34, 8'hA5, 8'h11, 8'h30, 8'h60, 8'h20,
    8'h01, 8'h11, 8'h21, 8'h11, 8'h9F, 8'h8F, 8'hFF, 8'hFF, 8'h9F};
  // register preload and final contents, address in the upper byte
  logic [15:0] rf_init [0:10] = '{16'hC102, 16'hC203, 16'h1080, 16'h1112, 16'h127F, 16'h2055, 16'h3005,
    16'h310A, 16'hC37F, 16'hC4C5, 16'hC580};
  logic [15:0] rf_exp [0:9] = '{16'h107F, 16'h1200, 16'hC103, 16'hC203, 16'h20AA, 16'h3005, 16'h310A,
    16'hC37F, 16'hC580, 16'h1112};
  // cycles, flags and system mode after each instruction
  int lens [0:18] = '{4, 4, 4, 4, 4, 4, 4, 6, 6, 6, 6, 4, 4, 4, 4, 4, 4, 4, 4};
  logic [7:0] flv [0:18] = '{8'h80, 8'hA0, 8'h90, 8'hB0, 8'h80, 8'h80, 8'h80, 8'h40, 8'hA0, 8'hB0, 8'h00,
    8'h20, 8'h20, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
  logic [7:0] smv [0:18] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 8'h08, 0, 0, 0, 8'h08};

  // free-running clock
  always #50 clk = ~clk;

  ucp_core dut_u (
    .clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .bus_req_i(bus_req), .bus_rdata_o(bus_rdata),
    .pm_addr_o(pm_addr), .pm_data_i(pm_data), .rf_o(rf_port), .rf_rdata_i(rf_rdata), .irq_req_i(irq_req),
    .irq_vector_i(irq_vector), .irq_ack_o(irq_ack), .ret_pc_o(ret_pc), .cpu_clk_en_o(cpu_clk_en),
    .sysmode_o(sysmode)
  );

  ucp_mem_model mem_u (
    .clk_i(clk), .pm_addr_i(pm_addr), .pm_data_o(pm_data), .rf_i(rf_port), .rf_rdata_o(rf_rdata)
  );

  // count vector acknowledges where the pulse is settled
  always @(negedge clk)
    if (irq_ack === 1'b1)
      ack_n <= ack_n + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && n_tests > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one instruction slot: check the previous read, system mode in the next fetch cycle, read flags at that fetch edge
  task automatic step(input int len, input logic [7:0] fl, input logic [7:0] sm);
    @(negedge clk);
    if (pend)
    begin
      check(bus_rdata, pend_fl);
    end
    repeat (len - 1) @(posedge clk);
    bus_req.re <= 1'b1;
    bus_req.addr <= 8'hD5;
    @(negedge clk);
    check(sysmode, sm);
    @(posedge clk);
    bus_req.re <= 1'b0;
    pend = 1'b1;
    pend_fl = fl;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    bus_req.we <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clk);
    bus_req.we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    bus_req.re <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    bus_req.re <= 1'b0;
    @(negedge clk);
    check(bus_rdata, e);
    @(posedge clk);
  endtask

  task automatic wait_en(input logic v);
    int k;
    for (k = 0; k < 40 && cpu_clk_en !== v; k++) @(negedge clk);
    check(cpu_clk_en, v);
  endtask

  // watchdog against a hang
  initial
  begin
    #400000;
    bad_count++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    for (i = 0; i < 256; i++)
    begin
      mem_u.pm[i] = 8'hFF;
      mem_u.rf[i] = 8'h00;
    end
    for (i = 0; i < 34; i++) mem_u.pm[i] = prog[i];
    for (i = 0; i < 11; i++) mem_u.rf[rf_init[i][15:8]] = rf_init[i][7:0];
    mem_u.pm[8'h60] = 8'h6F;
    repeat (15) @(posedge clk);
    @(negedge clk);
    check(pm_addr, 16'h0000);
    check({sysmode, bus_rdata}, 16'h0000);
    check(cpu_clk_en, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // instruction sequence, request raised once servicing is off
    for (i = 0; i < 19; i++)
    begin
      if (i == 16)
        irq_req <= 1'b1;
      if (i == 18)
        check(ack_n, 0);
      step(lens[i], flv[i], smv[i]);
    end
    @(negedge clk);
    check(bus_rdata, pend_fl);
    for (i = 0; i < 256; i++)
      if (i < 10)
        check(mem_u.rf[rf_exp[i][15:8]], rf_exp[i][7:0]);
    for (i = 0; i < 40 && ack_n != 1; i++) @(negedge clk);
    check(ack_n, 1);
    @(posedge clk);
    irq_req <= 1'b0;
    // service routine starts with idle
    wait_en(1'b0);
    check(ret_pc, 16'h0022);
    check(sysmode, 8'h00);
    @(posedge clk);
    irq_req <= 1'b1;
    wait_en(1'b1);
    @(posedge clk);
    irq_req <= 1'b0;
    repeat (8) @(negedge clk);
    check(ack_n, 1);
    check(pm_addr[15:4], 12'h006);
    @(posedge clk);
    // software register port, unmapped place included
    bus_wr(8'hDE, 8'h08);
    bus_rd(8'hDE, 8'h08);
    bus_wr(8'hDE, 8'h00);
    bus_wr(8'hD5, 8'h5A);
    bus_rd(8'hD5, 8'h5A);
    bus_rd(8'h50, 8'h00);
    bus_wr(8'h50, 8'h33);
    bus_rd(8'h50, 8'h00);
    @(negedge clk);
    check(bus_rdata, 8'h00);
    // clock enable low freezes the sequencer
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    saved = pm_addr;
    repeat (3) @(negedge clk);
    check(pm_addr, saved);
    @(posedge clk);
    ce <= 1'b1;
    // idle left by reset
    for (i = 0; i < 256; i++) mem_u.pm[i] = 8'h6F;
    wait_en(1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check(cpu_clk_en, 1'b1);
    check(pm_addr, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule

`default_nettype wire
